//--- core/safety_pkg.sv
// Functional notes
// - After reset extension, go diagnostic unless locked
// - Safe-exit command moves safe to diagnostic
// - Reset output rises from reset, stays from safe
// - Diagnostic from reset initializes watchdog, error monitor
// - Diagnostic from reset disables driver; safe keeps
// - Reset-pin monitor: full init or status-only clear
// - Clear-wakeup command sends device to off
// - Config writes only when diagnostic and unlocked
// - Diagnostic time-out enters safe, sets flag
// - Mask blocks time-out; watchdog threshold still resets
// - Watchdog time-out or watchdog config write restarts sequence
// - Active only from diagnostic with fail flags clear
// - Active state ignores configuration writes
// - Driver enable only below watchdog output threshold
// - Self-test pulses output without safe entry
// - Safe on global condition, error threshold, lock
// - Safe entry, except from reset, counts errors, drops driver output
// - No watchdog reset in safe until safe-exit
// - Safe time-out selectable, off only when locked
// - Disable and lock threshold reset, diagnostic-only
// - Locked device returns to safe after reset
// - Priority: off, then reset, then stay safe
// - Reset entry drops outputs, restores defaults
package safety_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int DIAG_TIMEOUT_MS = 256;
  localparam int SAFE_TIMEOUT_BASE_MS = 32;
  localparam int TEST_PULSE_US = 10;
  localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SAFE_TIMEOUT_BASE_CYC =
    SAFE_TIMEOUT_BASE_MS * (CLK_HZ / 1000);
  localparam int TEST_PULSE_CYC = TEST_PULSE_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] SAFE_CFG_OFS = 8'h08;
  localparam logic [7:0] WD_CFG_OFS = 8'h0C;
  localparam logic [7:0] CRC_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] FLAG_OFS = 8'h18;

  // Command bit positions
  localparam int CMD_SAFE_EXIT = 0;
  localparam int CMD_CLR_WAKE = 1;
  localparam int CMD_UNLOCK = 2;
  localparam int CMD_MASK_DIAG = 3;
  localparam int CMD_LEAVE_DIAG = 4;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'hC;
  localparam logic [14:0] SAFE_CFG_RST = 15'h0404;
  localparam logic [11:0] WD_CFG_RST = 12'h481;
  localparam logic [8:0] CRC_RST = 9'h000;
  localparam logic [3:0] WATCHDOG_FAILURE_COUNTER_RST = 4'h5;
  localparam logic [3:0] ESM_FC_RST = 4'h0;
  localparam logic [4:0] FLAG_STATUS_ONLY = 5'h18;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    st_off, st_reset, st_diag, st_active, st_safe
  } op_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic off_cond;
    logic reset_cond;
    logic safe_cond;
    logic ext_done;
    logic wd_timeout;
    logic wd_good;
    logic wd_bad;
    logic esm_bad;
    logic analog_self_test_pulse;
    logic endrv_mismatch;
    logic system_reset_out_mismatch;
  } dev_event_t;

endpackage : safety_pkg

//--- core/safety_state_controller.sv
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module safety_state_controller
  import safety_pkg::*;
#(
  parameter int DIAG_TO_CYC = DIAG_TIMEOUT_CYC,
  parameter int SAFE_TO_BASE_CYC = SAFE_TIMEOUT_BASE_CYC
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device events
  input wire dev_event_t ev_i,
  // Pins and status
  output logic system_reset_out_o,
  output logic enable_interrupt_out_o,
  output logic wd_sequence_restart_o,
  output logic off_request_o,
  output op_state_t state_o
);

  // ****************************************
  // Storage
  // ****************************************
  op_state_t state_reg, state_next;
  logic [31:0] timer_reg;
  logic [3:0] ctrl_reg;
  logic [14:0] safe_cfg_reg;
  logic [11:0] wd_cfg_reg;
  logic [8:0] crc_reg;
  logic [4:0] flag_reg;
  logic [3:0] watchdog_failure_counter_reg, esm_fc_reg, dev_err_reg;
  logic unlocked_reg, mask_reg, ack_reg, system_reset_out_reg, eio_reg, restart_reg;
  logic [31:0] rdata_reg;
  logic [15:0] pulse_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = wb_i.cyc & wb_i.stb & ~ack_reg;
  // Only full-word writes land; partial ones are acked and dropped
  wire wr_ok = bus_req & wb_i.we & (wb_i.sel == 4'hF);
  wire wr_cmd = wr_ok & (wb_i.adr == CMD_OFS);
  wire wr_ctrl = wr_ok & (wb_i.adr == CTRL_OFS);
  wire wr_flag = wr_ok & (wb_i.adr == FLAG_OFS);
  wire cfg_open = (state_reg == st_diag) & unlocked_reg;
  wire wr_safe_cfg = wr_ok & cfg_open & (wb_i.adr == SAFE_CFG_OFS);
  wire wr_wd_cfg = wr_ok & cfg_open & (wb_i.adr == WD_CFG_OFS);
  wire wr_crc = wr_ok & cfg_open & (wb_i.adr == CRC_OFS);

  // Command strobes
  wire cmd_safe_exit = wr_cmd & wb_i.dat[CMD_SAFE_EXIT];
  wire cmd_clr_wake = wr_cmd & wb_i.dat[CMD_CLR_WAKE];
  wire cmd_unlock = wr_cmd & wb_i.dat[CMD_UNLOCK];
  wire cmd_mask = wr_cmd & wb_i.dat[CMD_MASK_DIAG];
  wire cmd_leave = wr_cmd & wb_i.dat[CMD_LEAVE_DIAG];

  // Field views
  wire drv_en = ctrl_reg[0];
  wire esm_en = ctrl_reg[1];
  wire [1:0] safe_to_sel = safe_cfg_reg[1:0];
  wire safe_timeout_disable = safe_cfg_reg[2];
  wire [3:0] safe_lock_threshold = safe_cfg_reg[7:4];
  wire [3:0] esm_th = safe_cfg_reg[11:8];
  wire [2:0] irq_en = safe_cfg_reg[14:12];
  wire watchdog_reset_enable = wd_cfg_reg[0];
  wire [3:0] wd_rst_th = wd_cfg_reg[7:4];
  wire [3:0] wd_oe_th = wd_cfg_reg[11:8];

  // ****************************************
  // Conditions
  // ****************************************
  wire wd_reset_hit = watchdog_reset_enable & (watchdog_failure_counter_reg >= wd_rst_th);
  wire esm_trip = esm_fc_reg >= esm_th;
  wire safe_lock = dev_err_reg > safe_lock_threshold;
  wire safe_to_on = ~(safe_timeout_disable & safe_lock);
  wire [31:0] safe_limit = SAFE_TO_BASE_CYC << safe_to_sel;
  wire diag_expired = timer_reg >= 32'(DIAG_TO_CYC - 1);
  wire safe_expired = timer_reg >= safe_limit - 32'h1;
  wire diag_to_evt = diag_expired & ~mask_reg;
  wire wd_below_oe = watchdog_failure_counter_reg < wd_oe_th;
  wire op_state = (state_reg == st_diag) | (state_reg == st_active) |
    (state_reg == st_safe);

  // Watchdog reset: diagnostic only while masked, safe only with safe-exit
  wire wd_reset_req = wd_reset_hit & (((state_reg == st_diag) & mask_reg) |
    (state_reg == st_active) |
    ((state_reg == st_safe) & cmd_safe_exit));

  // ****************************************
  // Transition arbitration
  // ****************************************
  always_comb begin
    state_next = state_reg;
    if (op_state & (ev_i.off_cond | cmd_clr_wake)) begin
      state_next = st_off;
    end else if (op_state & (ev_i.reset_cond | wd_reset_req)) begin
      state_next = st_reset;
    end else if ((state_reg == st_safe) & ev_i.safe_cond) begin
      state_next = st_safe;
    end else begin
      unique case (state_reg)
        st_reset: begin
          if (ev_i.ext_done & ~ev_i.reset_cond) begin
            state_next = safe_lock ? st_safe : st_diag;
          end
        end
        st_diag: begin
          if (ev_i.safe_cond | esm_trip | diag_to_evt) begin
            state_next = st_safe;
          end else if (cmd_leave & ~flag_reg[1] & ~flag_reg[2]) begin
            state_next = st_active;
          end
        end
        st_active: begin
          if (ev_i.safe_cond | esm_trip) begin
            state_next = st_safe;
          end
        end
        st_safe: begin
          if (cmd_safe_exit) begin
            state_next = st_diag;
          end else if (safe_to_on & safe_expired) begin
            state_next = st_reset;
          end
        end
        st_off: state_next = st_off;
      endcase
    end
  end

  // Entry events
  wire changed = state_next != state_reg;
  wire diag_from_reset = (state_reg == st_reset) & (state_next == st_diag);
  wire diag_from_safe = (state_reg == st_safe) & (state_next == st_diag);
  wire enter_active = changed & (state_next == st_active);
  wire enter_safe = changed & (state_next == st_safe);
  wire enter_reset = op_state & (state_next == st_reset);
  wire full_init = enter_reset | diag_from_reset;
  wire diag_to_set = (state_reg == st_diag) & diag_to_evt & enter_safe;

  // Flags: a set in the same cycle as its clear wins
  wire [4:0] flag_set = {ev_i.system_reset_out_mismatch, ev_i.endrv_mismatch,
    ev_i.esm_bad, ev_i.wd_bad, diag_to_set};
  wire [4:0] flag_clr = (wr_flag ? wb_i.dat[4:0] : 5'h00) |
    (full_init ? 5'h1F : 5'h00) |
    (diag_from_safe ? FLAG_STATUS_ONLY : 5'h00);
  wire [4:0] flag_next = (flag_reg & ~flag_clr) | flag_set;

  // Watchdog failure counter, saturating both ways
  wire wd_inc = ev_i.wd_bad | wr_wd_cfg;
  wire [3:0] watchdog_failure_counter_next = (wd_inc & ~ev_i.wd_good & (watchdog_failure_counter_reg != 4'hF)) ?
    watchdog_failure_counter_reg + 4'h1 : (ev_i.wd_good & ~wd_inc & (watchdog_failure_counter_reg != 4'h0)) ?
    watchdog_failure_counter_reg - 4'h1 : watchdog_failure_counter_reg;

  // ****************************************
  // State and timer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= st_reset;
      timer_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      timer_reg <= changed ? 32'h0 : timer_reg + {31'h0, ~&timer_reg};
    end
  end

  // ****************************************
  // Control and lock bits
  // ****************************************
  // Drivers and monitors: full init from reset, kept as they are from safe
  always_ff @(posedge clk_i) begin
    if (rst_i | full_init) begin
      ctrl_reg <= CTRL_RST;
    end else if (enter_safe) begin
      ctrl_reg <= {ctrl_reg[3:1], 1'b0};
    end else if (wr_ctrl & op_state) begin
      ctrl_reg <= {wb_i.dat[3:1], wb_i.dat[0] & wd_below_oe};
    end
  end

  // Unlock lasts only for the current diagnostic visit
  always_ff @(posedge clk_i) begin
    if (rst_i | (state_next != st_diag)) begin
      unlocked_reg <= 1'b0;
    end else if (cmd_unlock) begin
      unlocked_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i | enter_reset) begin
      mask_reg <= 1'b0;
    end else if (cmd_mask & (state_reg == st_diag)) begin
      mask_reg <= 1'b1;
    end
  end

  // ****************************************
  // Configuration
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      safe_cfg_reg <= SAFE_CFG_RST;
      crc_reg <= CRC_RST;
    end else begin
      if (wr_safe_cfg) safe_cfg_reg <= wb_i.dat[14:0];
      if (wr_crc) crc_reg <= wb_i.dat[8:0];
    end
  end

  // Watchdog setup is among the settings a reset entry restores
  always_ff @(posedge clk_i) begin
    if (rst_i | full_init) begin
      wd_cfg_reg <= WD_CFG_RST;
    end else if (wr_wd_cfg) begin
      wd_cfg_reg <= wb_i.dat[11:0];
    end
  end

  // ****************************************
  // Counters and flags
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i | full_init | enter_active) begin
      watchdog_failure_counter_reg <= WATCHDOG_FAILURE_COUNTER_RST;
      esm_fc_reg <= ESM_FC_RST;
    end else begin
      watchdog_failure_counter_reg <= watchdog_failure_counter_next;
      if (ev_i.esm_bad & esm_en & (esm_fc_reg != 4'hF)) begin
        esm_fc_reg <= esm_fc_reg + 4'h1;
      end
    end
  end

  // Error count survives reset entries so the lock can hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_err_reg <= 4'h0;
    end else if (enter_safe & (state_reg != st_reset) &
        (dev_err_reg != 4'hF)) begin
      dev_err_reg <= dev_err_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 5'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire pulse_start = (state_reg == st_active) & drv_en & (|irq_en) &
    ev_i.analog_self_test_pulse & (pulse_reg == 16'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_reg <= 16'h0;
    end else if (pulse_start) begin
      pulse_reg <= 16'(TEST_PULSE_CYC);
    end else if (pulse_reg != 16'h0) begin
      pulse_reg <= pulse_reg - 16'h1;
    end
  end

  // Reset and enable pins follow the next state so entry effects show on the same edge as the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_reset_out_reg <= 1'b0;
      eio_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      system_reset_out_reg <= (state_next == st_diag) | (state_next == st_active) |
        (state_next == st_safe);
      eio_reg <= ((state_next == st_diag) | (state_next == st_active)) &
        drv_en & ~enter_safe & ~pulse_start & (pulse_reg <= 16'h1);
      restart_reg <= op_state & (ev_i.wd_timeout | wr_wd_cfg);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] status_word = {14'h0, unlocked_reg, mask_reg, esm_fc_reg,
    watchdog_failure_counter_reg, dev_err_reg, 1'b0, state_reg};
  wire [31:0] rd_data =
    (wb_i.adr == CTRL_OFS) ? {28'h0, ctrl_reg} :
    (wb_i.adr == SAFE_CFG_OFS) ? {17'h0, safe_cfg_reg} :
    (wb_i.adr == WD_CFG_OFS) ? {20'h0, wd_cfg_reg} :
    (wb_i.adr == CRC_OFS) ? {23'h0, crc_reg} :
    (wb_i.adr == STATUS_OFS) ? status_word :
    (wb_i.adr == FLAG_OFS) ? {27'h0, flag_reg} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      rdata_reg <= bus_req ? rd_data : rdata_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign system_reset_out_o = system_reset_out_reg;
  assign enable_interrupt_out_o = eio_reg;
  assign wd_sequence_restart_o = restart_reg;
  assign off_request_o = state_reg == st_off;
  assign state_o = state_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_exit_diag_a: assert property ((state_reg == st_reset) & ev_i.ext_done &
    ~ev_i.reset_cond & ~safe_lock |=> state_reg == st_diag)
    else $error("reset exit did not reach diagnostic");
  safe_exit_diag_a: assert property ((state_reg == st_safe) & cmd_safe_exit &
    ~ev_i.off_cond & ~ev_i.reset_cond & ~ev_i.safe_cond & ~cmd_clr_wake &
    ~wd_reset_hit |=> state_reg == st_diag)
    else $error("safe exit did not reach diagnostic");
  system_reset_out_diag_high_a: assert property (diag_from_reset | diag_from_safe
    |=> system_reset_out_o [*2])
    else $error("reset output low in diagnostic");
  driver_init_a: assert property (diag_from_reset |=> !drv_en)
    else $error("driver enable survived reset entry");
  cfg_lock_a: assert property (wr_ok & (wb_i.adr == SAFE_CFG_OFS) &
    ~cfg_open |=> $stable(safe_cfg_reg))
    else $error("locked configuration changed");
  diag_timeout_a: assert property (diag_to_set
    |=> (state_reg == st_safe) && flag_reg[0])
    else $error("diagnostic time-out not taken");
  wd_cfg_inc_a: assert property (wr_wd_cfg & ~ev_i.wd_good &
    (watchdog_failure_counter_reg < 4'hF) & ~full_init & ~enter_active
    |=> (watchdog_failure_counter_reg == $past(watchdog_failure_counter_reg) + 4'h1) ##0 wd_sequence_restart_o)
    else $error("watchdog update miscounted");
  active_entry_a: assert property (enter_active
    |=> (watchdog_failure_counter_reg == WATCHDOG_FAILURE_COUNTER_RST) && (esm_fc_reg == ESM_FC_RST))
    else $error("counters not restored on active entry");
  drv_gate_a: assert property (wr_ctrl & wb_i.dat[0] & ~wd_below_oe &
    op_state & ~full_init |=> !drv_en)
    else $error("driver enabled above threshold");
  safe_entry_a: assert property (enter_safe & (state_reg != st_reset) &
    (dev_err_reg < 4'hF) |=> (dev_err_reg == $past(dev_err_reg) + 4'h1)
    ##1 !enable_interrupt_out_o)
    else $error("safe entry effects missing");
  off_first_a: assert property (op_state & ev_i.off_cond
    |=> state_reg == st_off)
    else $error("off condition lost priority");
  reset_pins_a: assert property ((state_reg == st_reset) &
    (state_next == st_reset) |=> !system_reset_out_o && !enable_interrupt_out_o)
    else $error("outputs high in reset");
  pulse_low_a: assert property (pulse_start & ~wr_ctrl &
    (state_next == st_active) |=>
    !enable_interrupt_out_o && drv_en && (state_reg == st_active))
    else $error("self-test pulse misbehaved");

  active_reach_c: cover property (enter_active);
  safe_lock_c: cover property ((state_reg == st_reset) & safe_lock &
    ev_i.ext_done);
  diag_to_c: cover property (diag_to_set);
  pulse_c: cover property (pulse_start);

endmodule : safety_state_controller

//--- testbench/host_model.sv
`timescale 1ns/1ns
module host_model
  import safety_pkg::*;
(
  // System
  input wire logic clk_i,
  // Wishbone master
  output wb_req_t wb_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);

  initial wb_o = '0;

  // ****************************************
  // Bus cycles
  // ****************************************
  // Request held until ack is sampled high, then released for a cycle
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_i);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_i;
    // Released lines show the inverse so stale values are never trusted
    wb_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0,
              dat: ~dat};
  endtask : xfer

  // Command bits are single pulses in the command word
  task automatic cmd(input int b);
    logic [31:0] d;
    xfer(1'b1, CMD_OFS, 32'h1 << b, d);
  endtask : cmd

  // Lock opened first, expected checksum and check enable written after
  task automatic cfg(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    cmd(CMD_UNLOCK);
    xfer(1'b1, adr, dat, d);
    xfer(1'b1, CRC_OFS, {23'h0, 1'b1, dat[7:0]}, d);
  endtask : cfg

endmodule : host_model

//--- testbench/safety_state_controller_tb.sv
`timescale 1ns/1ns
module safety_state_controller_tb import safety_pkg::*;;

  // ****************************************
  // Signals
  // ****************************************
  // Shortened state timers keep the run brief
  localparam int DIAG_CYC = 50;
  localparam int SAFE_CYC = 20;
  localparam logic [10:0] EV_OFF = 11'h400;
  localparam logic [10:0] EV_RST = 11'h200;
  localparam logic [10:0] EV_SAFE = 11'h100;
  localparam logic [10:0] EV_EXT = 11'h080;
  localparam logic [10:0] EV_WDTO = 11'h040;
  localparam logic [10:0] EV_GOOD = 11'h020;
  localparam logic [10:0] EV_BAD = 11'h010;
  localparam logic [10:0] EV_ESM = 11'h008;
  localparam logic [10:0] EV_TEST = 11'h004;
  localparam logic [10:0] EV_MIS = 11'h003;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  typedef struct {logic [7:0] a; logic [31:0] e;} row_t;
  logic clk_i;
  logic rst_i;
  wb_req_t wb_i;
  dev_event_t ev_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, system_reset_out_o, enable_interrupt_out_o;
  logic wd_sequence_restart_o, off_request_o;
  op_state_t state_o;
  logic [31:0] d;
  row_t rows [7];
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int restarts = 0;
  int n, r0;

  safety_state_controller #(
    .DIAG_TO_CYC(DIAG_CYC),
    .SAFE_TO_BASE_CYC(SAFE_CYC)
  ) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ev_i(ev_i),
    .system_reset_out_o(system_reset_out_o),
    .enable_interrupt_out_o(enable_interrupt_out_o),
    .wd_sequence_restart_o(wd_sequence_restart_o),
    .off_request_o(off_request_o), .state_o(state_o)
  );

  host_model u_host (
    .clk_i(clk_i), .wb_o(wb_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o)
  );

  // ****************************************
  // Clock, cycle ceiling, restart counting
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Cuts a hang short; the whole run needs about 800 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("[ERR] %0t cycle limit reached", $time);
      results();
    end
  end

  always @(posedge clk_i) begin
    if (wd_sequence_restart_o === 1'b1) restarts <= restarts + 1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // State, reset pin, enable pin and off request in one compare
  task automatic look(input op_state_t s, input logic r, input logic e);
    chk({26'h0, state_o, system_reset_out_o, enable_interrupt_out_o,
         off_request_o}, {26'h0, s, r, e, s == st_off});
  endtask : look

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    u_host.xfer(1'b0, a, 32'h0, d);
    chk(d & m, e & m);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_host.xfer(1'b1, a, v, d);
  endtask : wr

  task automatic drive(input logic [10:0] e);
    @(posedge clk_i);
    ev_i <= dev_event_t'(e);
  endtask : drive

  task automatic pulse(input logic [10:0] e);
    drive(e);
    drive(11'h0);
  endtask : pulse

  // Samples just after the edge so every update has landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    ev_i = '0;
    // Registers after one time-out and a masked re-entry to diagnostic
    rows = '{'{CTRL_OFS, 32'(CTRL_RST)}, '{SAFE_CFG_OFS, 32'(SAFE_CFG_RST)},
      '{WD_CFG_OFS, 32'(WD_CFG_RST)}, '{CRC_OFS, 32'(CRC_RST)},
      '{FLAG_OFS, 32'h1}, '{STATUS_OFS, 32'h10512}, '{8'h1C, 32'h0}};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    look(st_reset, 1'b0, 1'b0);
    pulse(EV_EXT);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    n = 0;
    while (state_o !== st_safe && n < 100) begin
      tick(1);
      n++;
    end
    chk({31'h0, n >= DIAG_CYC - 4 && n <= DIAG_CYC + 1}, 32'h1);
    look(st_safe, 1'b1, 1'b0);
    u_host.cmd(CMD_SAFE_EXIT);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    u_host.cmd(CMD_MASK_DIAG);
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].a, rows[i].e, ALL);
    end
    wr(SAFE_CFG_OFS, 32'h1404);
    rd(SAFE_CFG_OFS, 32'h0404, ALL);
    r0 = restarts;
    u_host.cfg(SAFE_CFG_OFS, 32'h1404);
    rd(SAFE_CFG_OFS, 32'h1404, ALL);
    u_host.cfg(WD_CFG_OFS, 32'h481);
    pulse(EV_WDTO);
    tick(1);
    chk(32'(restarts - r0), 32'h2);
    rd(STATUS_OFS, 32'h600, 32'hF00);
    look(st_diag, 1'b1, 1'b0);
    // Leave refused while the watchdog fail flag stands
    pulse(EV_BAD);
    u_host.cmd(CMD_LEAVE_DIAG);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    wr(FLAG_OFS, 32'h2);
    u_host.cmd(CMD_LEAVE_DIAG);
    tick(1);
    look(st_active, 1'b1, 1'b0);
    rd(STATUS_OFS, 32'h500, 32'hF00);
    wr(SAFE_CFG_OFS, 32'h0);
    rd(SAFE_CFG_OFS, 32'h1404, ALL);
    wr(CTRL_OFS, 32'hD);
    rd(CTRL_OFS, 32'hC, 32'hF);
    pulse(EV_GOOD);
    pulse(EV_GOOD);
    wr(CTRL_OFS, 32'hD);
    tick(1);
    look(st_active, 1'b1, 1'b1);
    pulse(EV_TEST);
    tick(1);
    n = 0;
    while (enable_interrupt_out_o !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    chk({31'h0, n >= TEST_PULSE_CYC - 1 && n <= TEST_PULSE_CYC + 1},
        32'h1);
    look(st_active, 1'b1, 1'b1);
    pulse(EV_MIS);
    wr(CTRL_OFS, 32'h5);
    drive(EV_SAFE);
    tick(1);
    look(st_safe, 1'b1, 1'b0);
    rd(CTRL_OFS, 32'h4, 32'hF);
    rd(STATUS_OFS, 32'h20, 32'hF0);
    rd(FLAG_OFS, 32'h18, 32'h18);
    drive(11'h0);
    u_host.cmd(CMD_SAFE_EXIT);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    rd(CTRL_OFS, 32'h4, 32'hF);
    rd(FLAG_OFS, 32'h0, 32'h18);
    // Third safe entry, then a reset while the lock holds
    drive(EV_SAFE);
    tick(1);
    look(st_safe, 1'b1, 1'b0);
    drive(EV_SAFE | EV_RST);
    tick(1);
    look(st_reset, 1'b0, 1'b0);
    drive(11'h0);
    pulse(EV_EXT);
    tick(1);
    look(st_safe, 1'b1, 1'b0);
    rd(CTRL_OFS, 32'hC, 32'hF);
    rd(STATUS_OFS, 32'h30, 32'hF0);
    drive(EV_OFF | EV_RST);
    tick(1);
    look(st_off, 1'b0, 1'b0);
    drive(11'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    pulse(EV_EXT);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    // Lock threshold 1, safe time-out on at the shortest setting
    u_host.cfg(SAFE_CFG_OFS, 32'h1410);
    u_host.cmd(CMD_MASK_DIAG);
    repeat (3) pulse(EV_BAD);
    tick(1);
    look(st_reset, 1'b0, 1'b0);
    pulse(EV_EXT);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    // Same failure count unmasked: safe holds it until safe-exit
    repeat (3) pulse(EV_BAD);
    drive(EV_SAFE);
    tick(1);
    look(st_safe, 1'b1, 1'b0);
    drive(11'h0);
    tick(2);
    look(st_safe, 1'b1, 1'b0);
    u_host.cmd(CMD_SAFE_EXIT);
    tick(1);
    look(st_reset, 1'b0, 1'b0);
    pulse(EV_EXT);
    tick(1);
    look(st_diag, 1'b1, 1'b0);
    // Host error monitor counts up to its threshold, then safe
    wr(CTRL_OFS, 32'hE);
    repeat (4) pulse(EV_ESM);
    tick(1);
    look(st_safe, 1'b1, 1'b0);
    n = 0;
    while (state_o !== st_reset && n < 100) begin
      tick(1);
      n++;
    end
    chk({31'h0, n >= SAFE_CYC - 1 && n <= SAFE_CYC + 1}, 32'h1);
    look(st_reset, 1'b0, 1'b0);
    pulse(EV_EXT);
    tick(1);
    look(st_safe, 1'b1, 1'b0);
    u_host.cmd(CMD_CLR_WAKE);
    tick(1);
    look(st_off, 1'b0, 1'b0);
    results();
  end

endmodule : safety_state_controller_tb
